// ### bench/burst_power_monitor.sv
/* Checks for the burst power-up block.
 Bound to the top module; sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module burst_power_monitor
(
	// Clock and control
	input wire logic       core_clk,
	input wire logic       resetn,
	input wire logic       clk_en,
	// Bus
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [7:0] wb_dat_o,
	input wire logic       wb_ack_o,
	// Converter
	input wire logic       conv_start,
	input wire logic       analog_converter_power,
	input wire logic       analog_converter_track,
	input wire logic       conversion_done_flag
);
	logic rd_st;
	assign rd_st = wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == 8'hbc;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
	endsequence
	sequence pwr_rd_s;
		wb_ack_o && !wb_we_i && wb_adr_i == 8'hba;
	endsequence
	a_ack_answer: assert property (req_s |=> wb_ack_o) else $error("ack missing");
	a_ack_pulse: assert property (wb_ack_o && clk_en |=> !wb_ack_o) else $error("ack held");
	a_bit7_zero: assert property (pwr_rd_s |-> !wb_dat_o[7]) else $error("bit7 set");
	a_unused_zero: assert property (pwr_rd_s |-> wb_dat_o[6:4] == 3'h0)
		else $error("unused bits set");
	a_track_power: assert property (analog_converter_track |-> analog_converter_power)
		else $error("track unpowered");
	a_wake_delay: assert property (conv_start && clk_en && !analog_converter_power
		|=> !analog_converter_track [*8]) else $error("wake too short");
	a_conv_length: assert property ($rose(analog_converter_track)
		|-> analog_converter_track [*4]) else $error("conversion short");
	a_flag_after: assert property ($fell(analog_converter_track)
		|-> ##[0:2] conversion_done_flag) else $error("done flag late");
	a_flag_clear: assert property ($fell(conversion_done_flag)
		|-> $past(rd_st) || $past(rd_st, 2)) else $error("flag lost");
endmodule // burst_power_monitor
bind adc_burst_power_up_control burst_power_monitor u_mon (.core_clk, .resetn, .clk_en,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .conv_start,
	.analog_converter_power, .analog_converter_track, .conversion_done_flag);
`default_nettype wire

// ### bench/tb_adc_burst_power_up_control.sv
/* Self-checking bench for the burst power-up block.
 Drives every port itself; the monitor is bound in. */
`timescale 1ns/10ps
`default_nettype none
module tb_adc_burst_power_up_control;
	logic       core_clk = 0, resetn = 0, clk_en = 1, conv_start = 0, conv_start_pin = 0;
	logic       wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_sel_i = 0;
	logic [7:0] wb_adr_i = 8'h00, wb_dat_i = 8'h00, wb_dat_o, q, f, v;
	logic       wb_ack_o, analog_converter_power, analog_converter_track;
	logic       conversion_done_flag, irq;
	int         mismatches = 0, checks = 0, n, m;
	always #20 core_clk = ~core_clk;
	adc_burst_power_up_control DUT (.core_clk, .resetn, .clk_en, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .conv_start,
		.conv_start_pin, .analog_converter_power, .analog_converter_track,
		.conversion_done_flag, .irq);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic int reps(int c);
		return c == 0 ? 1 : (c > 5 ? 64 : 1 << (c + 1));
	endfunction
	function automatic int wake(logic [7:0] x);
		return (x + 1) * 10;
	endfunction
	task automatic chk(string s, logic [15:0] g, logic [15:0] e);
		checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic bus(logic w, logic s, logic [7:0] a, logic [7:0] d);
		int k;
		k = 0;
		@(posedge core_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {2'b11, w, s, a, d};
		// Request held until ack is sampled high at a rising edge
		do
		begin
			@(posedge core_clk);
			k++;
		end
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		chk("ack_wait", 16'(k), 16'h2);
		repeat (2) @(posedge core_clk);
		#1;
	endtask
	// Start, then time the wait and the burst
	task automatic go(logic p);
		@(posedge core_clk);
		{conv_start_pin, conv_start} <= {p, !p};
		@(posedge core_clk);
		{conv_start_pin, conv_start} <= 2'b00;
		#1;
		n = 0;
		while (analog_converter_track !== 1'b1 && n < 300)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		m = 0;
		while (analog_converter_track === 1'b1 && m < 300)
		begin
			@(posedge core_clk);
			#1;
			m++;
		end
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(32'hfb56));
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		chk("reset_out", {wb_ack_o, analog_converter_power, analog_converter_track,
			conversion_done_flag, irq}, 16'h0);
		bus(0, 1, 8'hba, 8'h00);
		chk("pwr_reset", q, 8'h0f);
		// Bit 7 kept zero on writes, as software must
		repeat (4)
		begin
			v = 8'($urandom) & 8'h7f;
			bus(1, 1, 8'hba, v);
			bus(0, 1, 8'hba, 8'h00);
			chk("pwr_field", q, v & 8'h0f);
		end
		bus(1, 0, 8'hba, 8'h03);
		bus(0, 1, 8'hba, 8'h00);
		chk("sel_low", q, v & 8'h0f);
		bus(0, 1, 8'hb0, 8'h00);
		chk("unmapped", q, 8'h00);
		bus(1, 1, 8'hbd, 8'h01);
		for (int c = 0; c < 6; c++)
		begin
			f = 8'($urandom % 16);
			bus(1, 1, 8'hba, f);
			bus(1, 1, 8'hbb, {3'h0, 3'(c), 2'b10});
			go(0);
			chk("wake", 16'(n >= wake(f) && n <= wake(f) + 2), 16'h1);
			chk("burst_len", 16'(m), 16'(4 * reps(c)));
			chk("sleep", {analog_converter_power, conversion_done_flag, irq}, 3'b011);
			bus(0, 1, 8'hbc, 8'h00);
			chk("status", q[3:0], 4'h3);
			bus(0, 1, 8'hbc, 8'h00);
			chk("cleared", {q[0], conversion_done_flag, irq}, 3'b000);
		end
		bus(1, 1, 8'hbb, 8'h03);
		bus(1, 1, 8'hbd, 8'h00);
		go(1);
		chk("pin_start", 16'(n <= 5), 16'h1);
		chk("stay_on", {analog_converter_power, conversion_done_flag, irq}, 3'b110);
		bus(1, 1, 8'hbd, 8'h01);
		chk("unmask", irq, 1'b1);
		bus(0, 1, 8'hbc, 8'h00);
		go(0);
		chk("at_once", 16'(n <= 2), 16'h1);
		bus(1, 1, 8'hba, 8'h0f);
		bus(1, 1, 8'hbb, 8'h00);
		chk("off", analog_converter_power, 1'b0);
		bus(1, 1, 8'hbb, 8'h01);
		chk("on", analog_converter_power, 1'b1);
		go(0);
		chk("no_delay", 16'(n <= 2), 16'h1);
		// Enable low: a start must not move the sequencer
		@(posedge core_clk);
		{clk_en, conv_start} <= 2'b01;
		@(posedge core_clk);
		conv_start <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		chk("frozen", {analog_converter_power, analog_converter_track}, 2'b10);
		@(posedge core_clk);
		clk_en <= 1'b1;
		close_out();
	end
	// Whole run is under two thousand cycles; allow ten thousand
	initial
	begin
		#400000;
		mismatches++;
		close_out();
	end
endmodule // tb_adc_burst_power_up_control
`default_nettype wire

// ### pkg/burst_power_pkg.sv
/*
 Constants for the converter burst power-up control block: register map,
 field layout, reset values, timing and states.
 Assumes a 25 MHz core clock and a classic Wishbone register bus.
*/
// Function
// RULE1 - Startup delay after wake is (power-up field plus one) times 400 ns.
// RULE2 - Burst disabled: power follows converter enable only, delay field unused.
// RULE3 - Burst and enable set: stay powered, convert at once on start.
// RULE4 - Burst set, enable clear: sleep after conversions, wait delay after start.
// RULE5 - Bit 7 reads zero; software must write zero there.
// RULE6 - Bits 6 to 4 read zero; writes to them ignored.
// RULE7 - Burst start launches repeat-count conversions; done flag after all.
// RULE8 - Starts in burst mode no faster than once per four clocks.
// RULE9 - Power-up wait is a down-counter ticking every 400 ns interval.
`default_nettype none
package burst_power_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] burst_power_up_register_idx = 8'hba;
	localparam logic [7:0] control_idx                 = 8'hbb;
	localparam logic [7:0] status_idx                  = 8'hbc;
	localparam logic [7:0] mask_idx                    = 8'hbd;
	localparam logic [7:0] burst_power_up_time_reset   = 8'h0f;
	localparam int         pwr_lsb   = 0;
	localparam int         pwr_msb   = 3;
	// Control bits
	localparam int         ctl_conv_en  = 0;
	localparam int         ctl_burst_en = 1;
	localparam int         ctl_rpt_lsb  = 2;
	localparam int         ctl_rpt_msb  = 4;
	// Status bits
	localparam int         st_done   = 0;
	localparam int         st_woke   = 1;
	localparam int         st_width  = 2;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int         clk_mhz        = 25;
	localparam int         tick_ns        = 400;
	localparam int         tick_cycles    = (tick_ns * clk_mhz) / 1000;
	localparam int         conv_cycles    = 4;
	typedef enum logic [1:0]
	{
		st_off   = 2'b00,
		st_idle  = 2'b01,
		st_wake  = 2'b10,
		st_conv  = 2'b11
	} power_state_e;
endpackage
`default_nettype wire

// ### rtl/adc_burst_power_up_control.sv
/*
 Power state and power-up delay sequencer for the converter burst mode,
 with Wishbone register slave and a level interrupt.
 Assumes start pulses are synchronous to core_clk; conv_start_pin is a pin.
*/
// Register access over Wishbone was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module adc_burst_power_up_control
(
	// Clock, reset, enable
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [7:0]  wb_dat_i,
	input  wire logic        wb_sel_i,
	output logic      [7:0]  wb_dat_o,
	output logic             wb_ack_o,
	// Convert start
	input  wire logic        conv_start,
	input  wire logic        conv_start_pin,
	// Converter
	output logic             analog_converter_power,
	output logic             analog_converter_track,
	output logic             conversion_done_flag,
	output logic             irq
);
	logic [7:0] burst_power_up_register;
	logic [4:0] control;
	logic [1:0] status;
	logic [1:0] mask;
	logic       pin_meta;
	logic       pin_sync;
	logic       pin_prev;
	logic       start;
	logic       access;
	logic       rd_status;
	logic [7:0] tick_cnt;
	logic [3:0] wake_cnt;
	logic [7:0] conv_cnt;
	logic [6:0] rpt_left;
	logic       done_evt;
	logic       woke_evt;
	burst_power_pkg::power_state_e state;

	wire conv_en  = control[burst_power_pkg::ctl_conv_en];
	wire burst_en = control[burst_power_pkg::ctl_burst_en];
	wire [2:0] rpt_code = control[burst_power_pkg::ctl_rpt_msb:burst_power_pkg::ctl_rpt_lsb];

	// Repeat code 0..5 selects 1, 4, 8, 16, 32, 64
	function automatic logic [6:0] repeat_count(input logic [2:0] code);
		unique case (code)
			3'h0: repeat_count = 7'h01;
			3'h1: repeat_count = 7'h04;
			3'h2: repeat_count = 7'h08;
			3'h3: repeat_count = 7'h10;
			3'h4: repeat_count = 7'h20;
			default: repeat_count = 7'h40;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Start sources
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_prev <= 1'b0;
		end
		else if (clk_en)
		begin
			pin_meta <= conv_start_pin;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end
	// Sources must space starts by four clocks; any start during wake or conversion is dropped
	assign start = conv_start | (pin_sync & ~pin_prev); // RULE8

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	assign access    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign rd_status = access & ~wb_we_i & (wb_adr_i == burst_power_pkg::status_idx);

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			wb_ack_o <= 1'b0;
		else if (clk_en)
			wb_ack_o <= access;
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			burst_power_up_register <= burst_power_pkg::burst_power_up_time_reset;
			control                 <= 5'h00;
			mask                    <= 2'h0;
		end
		else if (clk_en && access && wb_we_i && wb_sel_i)
		begin
			unique case (wb_adr_i)
				burst_power_pkg::burst_power_up_register_idx:
					// Upper bits are not stored, so they read zero
					burst_power_up_register <= {4'h0, wb_dat_i[burst_power_pkg::pwr_msb:
						burst_power_pkg::pwr_lsb]}; // RULE5 RULE6
				burst_power_pkg::control_idx:
					control <= wb_dat_i[4:0];
				burst_power_pkg::mask_idx:
					mask <= wb_dat_i[1:0];
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			wb_dat_o <= 8'h00;
		else if (clk_en && access && !wb_we_i)
		begin
			unique case (wb_adr_i)
				burst_power_pkg::burst_power_up_register_idx:
					wb_dat_o <= burst_power_up_register;
				burst_power_pkg::control_idx:
					wb_dat_o <= {3'h0, control};
				burst_power_pkg::status_idx:
					wb_dat_o <= {4'h0, state, status};
				burst_power_pkg::mask_idx:
					wb_dat_o <= {6'h00, mask};
				default:
					wb_dat_o <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Power sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			state    <= burst_power_pkg::st_off;
			tick_cnt <= 8'h00;
			wake_cnt <= 4'h0;
			conv_cnt <= 8'h00;
			rpt_left <= 7'h00;
			done_evt <= 1'b0;
			woke_evt <= 1'b0;
		end
		else if (clk_en)
		begin
			done_evt <= 1'b0;
			woke_evt <= 1'b0;
			unique case (state)
				burst_power_pkg::st_off:
					// Enable set keeps the converter powered, burst or not
					if (conv_en)
						state <= burst_power_pkg::st_idle; // RULE2 RULE3
					else if (burst_en && start)
					begin
						// Sleeping in burst mode: wait the programmed power-up time
						state    <= burst_power_pkg::st_wake; // RULE4
						wake_cnt <= burst_power_up_register[3:0]; // RULE9
						tick_cnt <= 8'(burst_power_pkg::tick_cycles - 1);
						rpt_left <= repeat_count(rpt_code);
					end
				burst_power_pkg::st_idle:
					if (!conv_en)
						state <= burst_power_pkg::st_off; // RULE2
					else if (start)
					begin
						// Powered: convert at once, no power-up delay
						state    <= burst_power_pkg::st_conv; // RULE3
						conv_cnt <= 8'(burst_power_pkg::conv_cycles - 1);
						rpt_left <= burst_en ? repeat_count(rpt_code) : 7'h01;
					end
				burst_power_pkg::st_wake:
					// (field + 1) intervals of 400 ns
					if (tick_cnt != 8'h00)
						tick_cnt <= tick_cnt - 8'h01; // RULE1
					else if (wake_cnt != 4'h0)
					begin
						wake_cnt <= wake_cnt - 4'h1; // RULE9
						tick_cnt <= 8'(burst_power_pkg::tick_cycles - 1);
					end
					else
					begin
						state    <= burst_power_pkg::st_conv; // RULE1
						woke_evt <= 1'b1;
						conv_cnt <= 8'(burst_power_pkg::conv_cycles - 1);
					end
				burst_power_pkg::st_conv:
					if (conv_cnt != 8'h00)
						conv_cnt <= conv_cnt - 8'h01;
					else if (rpt_left > 7'h01)
					begin
						// Back-to-back conversions within one burst
						rpt_left <= rpt_left - 7'h01; // RULE7
						conv_cnt <= 8'(burst_power_pkg::conv_cycles - 1);
					end
					else
					begin
						done_evt <= 1'b1; // RULE7
						state    <= (conv_en || !burst_en) ? burst_power_pkg::st_idle
							: burst_power_pkg::st_off; // RULE3 RULE4
					end
			endcase
		end
	end

	assign analog_converter_power = (state != burst_power_pkg::st_off); // RULE2
	assign analog_converter_track = (state == burst_power_pkg::st_conv);

	// ----------------------------------------------------------------
	// Interrupts: read of status clears, a new event wins over the clear
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			status <= 2'h0;
		else if (clk_en)
			status <= (rd_status ? 2'h0 : status) | {woke_evt, done_evt};
	end

	assign conversion_done_flag = status[burst_power_pkg::st_done];
	assign irq                  = |(status & mask);
endmodule // adc_burst_power_up_control
`default_nettype wire
